// ===== inc/pwr_ctl_map.vh
// constants for the idle/sleep and wake-up controller
`ifndef PWR_CTL_MAP_VH
`define PWR_CTL_MAP_VH
`define WS_W 3
`define WS_RST 3'h3
`define WDT_CNT_W 18
`define SST_CNT_W 10
`define SST_CYCLES 10'h3ff
`define SYSDIV_W 2
`define SYSDIV_LAST 2'h3
`endif

// ===== rtl/wake_edge_det.v
// per-pin synchroniser and falling edge detector for port a wake
`timescale 1ns/10ps
module wake_edge_det
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_sys_rst,
  // pin and enable
  input wire i_pin,
  input wire i_wake_en,
  // falling edge seen on an enabled pin
  output wire o_fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;

  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign o_fall = i_wake_en & last_q & ~sync_q;

endmodule // wake_edge_det

// ===== rtl/idle_mode_wakeup_control.v
// halt-mode entry, clock gating, watchdog and wake-up control
`timescale 1ns/10ps
`include "pwr_ctl_map.vh"
module idle_mode_wakeup_control
#(
  parameter PINS = 8,
  parameter NIRQ = 4
)
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_sys_rst,
  // core side
  input wire i_halt,
  input wire i_clr_wdt,
  input wire i_idle_select_bit,
  input wire i_idle_sysclk_keep_bit,
  input wire i_fast_wake_enable,
  input wire i_sysclk_is_hxt,
  input wire i_sysclk_is_sub,
  input wire i_stack_full,
  // watchdog configuration
  input wire i_wdt_enable,
  input wire i_wdt_src_sub,
  input wire i_sub_from_lxt,
  input wire [`WS_W-1:0] i_watchdog_period_select,
  // sub clock tick and crystal requests
  input wire i_sub_tick,
  input wire i_hxt_start,
  input wire i_lxt_start,
  // interrupts
  input wire [NIRQ-1:0] i_irq_req,
  input wire [NIRQ-1:0] i_irq_en,
  // port a
  input wire [PINS-1:0] i_porta_pin,
  input wire [PINS-1:0] i_porta_wake_enable_register,
  // status and control outputs
  output reg o_power_down_flag,
  output reg o_watchdog_timeout_flag,
  output reg o_halted,
  output reg o_sysclk_en,
  output reg o_subclk_en,
  output reg o_wdt_reset,
  output reg o_pc_sp_reset,
  output reg o_resume_next,
  output reg o_irq_service,
  output reg [NIRQ-1:0] o_irq_pending,
  output reg o_high_speed_osc_ready_flag,
  output reg o_lxt_ready,
  output reg o_allow_low_speed_switch,
  output reg o_periph_on_sub,
  output reg o_wdt_src_is_lxt
);
  localparam [4:0] S_RUN = 5'h01;
  localparam [4:0] S_FIRST_IDLE_MODE = 5'h02;
  localparam [4:0] S_SECOND_IDLE_MODE = 5'h04;
  localparam [4:0] S_SLP0 = 5'h08;
  localparam [4:0] S_SLP1 = 5'h10;
  localparam [2:0] T_IDLE = 3'h1;
  localparam [2:0] T_HXT = 3'h2;
  localparam [2:0] T_LXT = 3'h4;

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [`WDT_CNT_W-1:0] wdt_cnt_q;
  reg [`SYSDIV_W-1:0] sysdiv_q;
  reg [NIRQ-1:0] irq_mask_q;
  reg [2:0] sst_st_q;
  reg [`SST_CNT_W-1:0] sst_cnt_q;
  reg lxt_pend_q;
  reg from_deep_q;
  reg wdt_tick;
  reg wdt_run;
  reg wdt_ovf;
  reg [`WDT_CNT_W-1:0] ovf_mask;
  wire [PINS-1:0] fall_w;
  wire halted;
  wire pin_wake;
  wire [NIRQ-1:0] irq_wake;
  wire enter_halt;
  wire wake;

  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1)
    begin : g_pin
      wake_edge_det u_det
      (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_porta_pin[g]),
        .i_wake_en(i_porta_wake_enable_register[g]),
        .o_fall(fall_w[g])
      );
    end
  endgenerate

  assign halted = (state_q != S_RUN);
  assign enter_halt = i_halt & ~halted;
  assign pin_wake = |fall_w;
  assign irq_wake = i_irq_req & ~irq_mask_q;
  assign wake = halted & (pin_wake | (|irq_wake) | wdt_ovf);

  // halt mode chosen from the select bits as they stand at the halt
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_RUN:
      begin
        if (enter_halt)
        begin
          if (!i_idle_select_bit)
            state_d = i_wdt_enable ? S_SLP1 : S_SLP0;
          else if (i_idle_sysclk_keep_bit)
            state_d = S_SECOND_IDLE_MODE;
          else
            state_d = S_FIRST_IDLE_MODE;
        end
      end
      S_FIRST_IDLE_MODE, S_SECOND_IDLE_MODE, S_SLP0, S_SLP1:
      begin
        if (wake)
          state_d = S_RUN;
      end
      default:
        state_d = S_RUN;
    endcase
  end

  // watchdog source: sub clock tick or system clock divided by four
  always @*
  begin
    ovf_mask = {`WDT_CNT_W{1'b0}};
    case (i_watchdog_period_select)
      3'h0: ovf_mask[7:0] = 8'hff;
      3'h1: ovf_mask[9:0] = 10'h3ff;
      3'h2: ovf_mask[11:0] = 12'hfff;
      3'h3: ovf_mask[13:0] = 14'h3fff;
      3'h4: ovf_mask[14:0] = 15'h7fff;
      3'h5: ovf_mask[15:0] = 16'hffff;
      3'h6: ovf_mask[16:0] = 17'h1ffff;
      default: ovf_mask = {`WDT_CNT_W{1'b1}};
    endcase
    // the system clock source stalls whenever the system clock is gated
    if (i_wdt_src_sub)
      wdt_tick = i_sub_tick;
    else
      wdt_tick = (sysdiv_q == `SYSDIV_LAST) & o_sysclk_en;
    wdt_run = i_wdt_enable & (state_q != S_SLP0) & ~(state_q == S_SLP1 & ~i_wdt_src_sub);
    wdt_ovf = wdt_run & wdt_tick & ((wdt_cnt_q & ovf_mask) == ovf_mask);
  end

  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      state_q <= S_RUN;
      wdt_cnt_q <= {`WDT_CNT_W{1'b0}};
      sysdiv_q <= {`SYSDIV_W{1'b0}};
      irq_mask_q <= {NIRQ{1'b0}};
      o_power_down_flag <= 1'b0;
      o_watchdog_timeout_flag <= 1'b0;
      o_halted <= 1'b0;
      o_sysclk_en <= 1'b1;
      o_subclk_en <= 1'b1;
      o_wdt_reset <= 1'b0;
      o_pc_sp_reset <= 1'b0;
      o_resume_next <= 1'b0;
      o_irq_service <= 1'b0;
      o_irq_pending <= {NIRQ{1'b0}};
      o_allow_low_speed_switch <= 1'b0;
      o_periph_on_sub <= 1'b0;
      o_wdt_src_is_lxt <= 1'b0;
      from_deep_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      o_halted <= (state_d != S_RUN);
      o_sysclk_en <= (state_d == S_RUN) | (state_d == S_SECOND_IDLE_MODE);
      o_subclk_en <= (state_d != S_SLP0);
      o_periph_on_sub <= i_sysclk_is_sub;
      o_wdt_src_is_lxt <= i_wdt_src_sub & i_sub_from_lxt;
      sysdiv_q <= sysdiv_q + {{(`SYSDIV_W-1){1'b0}}, 1'b1};
      o_wdt_reset <= 1'b0;
      o_pc_sp_reset <= 1'b0;
      o_resume_next <= 1'b0;
      o_irq_service <= 1'b0;
      if (enter_halt)
      begin
        wdt_cnt_q <= {`WDT_CNT_W{1'b0}};
        irq_mask_q <= i_irq_req;
        from_deep_q <= ~i_idle_select_bit & ~i_wdt_enable;
      end
      else if (i_clr_wdt)
        wdt_cnt_q <= {`WDT_CNT_W{1'b0}};
      else if (wdt_run & wdt_tick)
        wdt_cnt_q <= wdt_ovf ? {`WDT_CNT_W{1'b0}} : wdt_cnt_q + {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
      // set by halt wins over a clear in the same cycle
      if (i_halt)
        o_power_down_flag <= 1'b1;
      else if (i_clr_wdt)
        o_power_down_flag <= 1'b0;
      if (wdt_ovf)
        o_watchdog_timeout_flag <= 1'b1;
      else if (enter_halt)
        o_watchdog_timeout_flag <= 1'b0;
      if (wdt_ovf & halted)
        o_pc_sp_reset <= 1'b1;
      else if (wdt_ovf)
        o_wdt_reset <= 1'b1;
      else if (wake)
      begin
        if (pin_wake)
          o_resume_next <= 1'b1;
        else if (|(irq_wake & i_irq_en) & ~i_stack_full)
          o_irq_service <= 1'b1;
        else
          o_resume_next <= 1'b1;
        o_allow_low_speed_switch <= (state_q == S_SLP1) & i_sysclk_is_hxt & i_fast_wake_enable;
      end
      else if (enter_halt)
        o_allow_low_speed_switch <= 1'b0;
      // the mask taken at halt entry must survive the entry cycle itself
      if (!halted & ~enter_halt)
        irq_mask_q <= {NIRQ{1'b0}};
      o_irq_pending <= i_irq_req & ~(i_irq_en & {NIRQ{~i_stack_full}});
    end
  end

  // shared start-up timer, high-speed crystal first, low-speed after
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      sst_st_q <= T_HXT;
      sst_cnt_q <= {`SST_CNT_W{1'b0}};
      lxt_pend_q <= 1'b1;
      o_high_speed_osc_ready_flag <= 1'b0;
      o_lxt_ready <= 1'b0;
    end
    else
    begin
      case (sst_st_q)
        T_IDLE:
        begin
          if (wake & from_deep_q)
          begin
            o_high_speed_osc_ready_flag <= 1'b0;
            lxt_pend_q <= i_lxt_start;
            sst_cnt_q <= {`SST_CNT_W{1'b0}};
            sst_st_q <= T_HXT;
          end
          else if (i_hxt_start & ~o_high_speed_osc_ready_flag)
          begin
            sst_cnt_q <= {`SST_CNT_W{1'b0}};
            sst_st_q <= T_HXT;
          end
          else if (i_lxt_start & ~o_lxt_ready)
          begin
            sst_cnt_q <= {`SST_CNT_W{1'b0}};
            sst_st_q <= T_LXT;
          end
        end
        T_HXT:
        begin
          sst_cnt_q <= sst_cnt_q + {{(`SST_CNT_W-1){1'b0}}, 1'b1};
          if (sst_cnt_q == `SST_CYCLES)
          begin
            o_high_speed_osc_ready_flag <= 1'b1;
            sst_cnt_q <= {`SST_CNT_W{1'b0}};
            sst_st_q <= lxt_pend_q ? T_LXT : T_IDLE;
          end
        end
        T_LXT:
        begin
          sst_cnt_q <= sst_cnt_q + {{(`SST_CNT_W-1){1'b0}}, 1'b1};
          if (sst_cnt_q == `SST_CYCLES)
          begin
            o_lxt_ready <= 1'b1;
            lxt_pend_q <= 1'b0;
            sst_st_q <= T_IDLE;
          end
        end
        default:
          sst_st_q <= T_IDLE;
      endcase
    end
  end

endmodule // idle_mode_wakeup_control

// ===== verification/idle_mode_wakeup_control_properties.sv
// assertions for the idle and wake-up controller
`timescale 1ns/10ps
module idle_mode_wakeup_control_properties
#(
  parameter PINS = 8,
  parameter NIRQ = 4
)
(
  // clock and reset
  input wire i_ref_clk,
  input wire i_sys_rst,
  // inputs
  input wire i_halt,
  input wire i_clr_wdt,
  input wire i_idle_select_bit,
  input wire i_idle_sysclk_keep_bit,
  input wire i_stack_full,
  input wire [NIRQ-1:0] i_irq_req,
  input wire [NIRQ-1:0] i_irq_en,
  input wire [PINS-1:0] i_porta_pin,
  input wire [PINS-1:0] i_porta_wake_enable_register,
  // outputs
  input wire o_power_down_flag,
  input wire o_watchdog_timeout_flag,
  input wire o_halted,
  input wire o_sysclk_en,
  input wire o_subclk_en,
  input wire o_pc_sp_reset,
  input wire o_resume_next,
  input wire o_irq_service
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_take;
    i_halt && !o_halted;
  endsequence
  sequence s_pin_fall;
    o_halted && |(i_porta_wake_enable_register & $past(i_porta_pin) & ~i_porta_pin);
  endsequence
  a_idle_zero_entry: assert property (s_take ##0 i_idle_select_bit && !i_idle_sysclk_keep_bit |=>
    o_halted && !o_sysclk_en && o_subclk_en) else $error("first_idle_mode entry");
  a_idle_one_entry: assert property (s_take ##0 i_idle_select_bit && i_idle_sysclk_keep_bit |=>
    o_halted && o_sysclk_en && o_subclk_en) else $error("second_idle_mode entry");
  a_sleep_entry: assert property (s_take ##0 !i_idle_select_bit |=> o_halted && !o_sysclk_en)
    else $error("sleep entry");
  a_entry_flags: assert property (s_take |=> o_power_down_flag && !o_watchdog_timeout_flag)
    else $error("entry flags");
  a_pdf_clear: assert property (i_clr_wdt && !i_halt |=> !o_power_down_flag)
    else $error("pdf clear");
  a_wake_cause: assert property ($fell(o_halted) && !$past(i_sys_rst) |->
    o_resume_next || o_irq_service || o_pc_sp_reset) else $error("wake cause");
  a_pin_wake_bound: assert property (s_pin_fall |-> ##[0:6] !o_halted)
    else $error("pin wake");
  a_pending_irq_blocked: assert property (s_take ##0 i_irq_req != 0 && i_porta_wake_enable_register == 0
    ##1 $stable(i_irq_req) [*4] |-> o_halted) else $error("pending irq woke");
  a_irq_serviced: assert property (o_halted && !i_stack_full && |(i_irq_en & i_irq_req & ~$past(i_irq_req))
    |-> ##[0:4] o_irq_service) else $error("irq service");
endmodule // idle_mode_wakeup_control_properties

bind idle_mode_wakeup_control idle_mode_wakeup_control_properties #(.PINS(PINS), .NIRQ(NIRQ)) u_props (
  .i_ref_clk, .i_sys_rst, .i_halt, .i_clr_wdt, .i_idle_select_bit, .i_idle_sysclk_keep_bit, .i_stack_full,
  .i_irq_req, .i_irq_en, .i_porta_pin, .i_porta_wake_enable_register, .o_power_down_flag,
  .o_watchdog_timeout_flag, .o_halted, .o_sysclk_en, .o_subclk_en, .o_pc_sp_reset, .o_resume_next, .o_irq_service);

// ===== verification/porta_model.sv
// port a model: pins pulled up, one pulled low on request
`timescale 1ns/10ps
module porta_model
(
  // request
  input wire i_go,
  input wire [2:0] i_idx,
  // pins
  output wire [7:0] o_pins
);
  // released pins go to the pull-up level
  assign o_pins = i_go ? ~(8'h01 << i_idx) : 8'hff;
endmodule // porta_model

// ===== verification/test_idle_mode_wakeup_control.sv
// self-checking bench for the idle and wake-up controller
`timescale 1ns/10ps
module test_idle_mode_wakeup_control;
  reg i_ref_clk = 0, i_sys_rst = 1, i_halt = 0, i_clr_wdt = 0, i_idle_select_bit = 0, i_idle_sysclk_keep_bit = 0;
  reg i_fast_wake_enable = 0, i_sysclk_is_hxt = 0, i_sysclk_is_sub = 0, i_stack_full = 0, i_wdt_enable = 0;
  reg i_sub_from_lxt = 0, go = 0, i_wdt_src_sub = 0, i_sub_tick = 0, sub_on = 0;
  reg [2:0] i_watchdog_period_select = 0, idx = 0;
  reg [3:0] i_irq_req = 0, i_irq_en = 0;
  reg [7:0] i_porta_wake_enable_register = 0;
  wire [7:0] i_porta_pin;
  wire [3:0] o_irq_pending;
  wire o_power_down_flag, o_watchdog_timeout_flag, o_halted, o_sysclk_en, o_subclk_en;
  wire o_high_speed_osc_ready_flag, o_lxt_ready;
  wire o_wdt_reset, o_pc_sp_reset, o_resume_next, o_irq_service, o_allow_low_speed_switch, o_periph_on_sub;
  wire o_wdt_src_is_lxt;
  integer seed = 39, n_errors = 0, check_count = 0, n = 0, ws = 0;
  always #10 i_ref_clk = ~i_ref_clk;
  // sub clock tick every second reference cycle while enabled
  always @(negedge i_ref_clk) i_sub_tick <= sub_on & ~i_sub_tick;
  porta_model pa (.i_go(go), .i_idx(idx), .o_pins(i_porta_pin));
  idle_mode_wakeup_control dut (.i_ref_clk, .i_sys_rst, .i_halt, .i_clr_wdt, .i_idle_select_bit,
    .i_idle_sysclk_keep_bit, .i_fast_wake_enable, .i_sysclk_is_hxt, .i_sysclk_is_sub, .i_stack_full, .i_wdt_enable,
    .i_wdt_src_sub, .i_sub_from_lxt, .i_watchdog_period_select, .i_sub_tick, .i_hxt_start(1'b1),
    .i_lxt_start(1'b1), .i_irq_req, .i_irq_en, .i_porta_pin, .i_porta_wake_enable_register, .o_power_down_flag,
    .o_watchdog_timeout_flag, .o_halted, .o_sysclk_en, .o_subclk_en, .o_wdt_reset, .o_pc_sp_reset,
    .o_resume_next, .o_irq_service, .o_irq_pending, .o_high_speed_osc_ready_flag, .o_lxt_ready,
    .o_allow_low_speed_switch, .o_periph_on_sub, .o_wdt_src_is_lxt);
  task tick(input integer k);
    repeat (k) @(negedge i_ref_clk);
  endtask
  task chk(input [127:0] what, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("mismatch %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  function busy(input integer k);
    busy = k == 0 ? o_high_speed_osc_ready_flag !== 1'b1 : k == 1 ? o_lxt_ready !== 1'b1 :
      k == 3 ? o_wdt_reset !== 1'b1 : o_halted === 1'b1;
  endfunction
  // sysclk/4 source: four reference cycles per watchdog tick
  function integer wdt_cycles(input integer w);
    wdt_cycles = 4 << (w < 4 ? 8 + 2 * w : 11 + w);
  endfunction
  task await(input integer k, input integer lim);
    begin
      n = 0;
      while (busy(k) && n < lim)
      begin
        tick(1);
        n = n + 1;
      end
      if (n >= lim)
      begin
        n_errors = n_errors + 1;
        report_and_stop;
      end
    end
  endtask
  task halt(input s, input k);
    begin
      {i_idle_select_bit, i_idle_sysclk_keep_bit, i_halt} = {s, k, 1'b1};
      tick(1);
      i_halt = 0;
      i_idle_select_bit = ~s;
      tick(2);
    end
  endtask
  initial
  begin
    {i_fast_wake_enable, i_sysclk_is_hxt, i_sysclk_is_sub, i_sub_from_lxt} = $random(seed);
    tick(3);
    i_sys_rst = 0;
    await(0, 3000);
    chk("hs_ready", n > 1018 && n < 1030, 1);
    await(1, 3000);
    chk("lxt_after_hs", n > 1018 && n < 1030, 1);
    chk("periph_sub", o_periph_on_sub, i_sysclk_is_sub);
    $display("test startup done");
    idx = $random(seed);
    i_porta_wake_enable_register = 8'h01 << idx;
    i_wdt_enable = 1;
    halt(1, 0);
    chk("first_idle_mode_sysclk", o_sysclk_en, 0);
    chk("first_idle_mode_subclk", o_subclk_en, 1);
    chk("pdf_set", o_power_down_flag, 1);
    tick(1200);
    chk("wdt_stopped", o_halted, 1);
    go = 1;
    await(2, 12);
    go = 0;
    chk("pin_resume", o_resume_next, 1);
    $display("test first_idle_mode done");
    ws = $random(seed) & 1;
    i_watchdog_period_select = ws;
    halt(1, 1);
    chk("second_idle_mode_sysclk", o_sysclk_en, 1);
    await(2, 5000);
    chk("wdt_period", n + 12 > wdt_cycles(ws) && n < wdt_cycles(ws) + 8, 1);
    chk("to_set", o_watchdog_timeout_flag, 1);
    chk("pdf_kept", o_power_down_flag, 1);
    chk("wdt_wake", o_pc_sp_reset, 1);
    i_clr_wdt = 1;
    tick(1);
    i_clr_wdt = 0;
    tick(1);
    chk("pdf_clr", o_power_down_flag, 0);
    $display("test second_idle_mode done");
    i_porta_wake_enable_register = 0;
    halt(0, 0);
    chk("sleep_sysclk", o_sysclk_en, 0);
    chk("to_clr", o_watchdog_timeout_flag, 0);
    i_irq_req = 4'h1;
    await(2, 10);
    chk("irq_resume", o_resume_next, 1);
    chk("allow_ls", o_allow_low_speed_switch, i_sysclk_is_hxt & i_fast_wake_enable);
    chk("irq_held", o_irq_pending[0], 1);
    halt(0, 0);
    tick(20);
    chk("pending_no_wake", o_halted, 1);
    {i_irq_en, i_irq_req} = 8'h23;
    await(2, 10);
    chk("irq_service", o_irq_service, 1);
    {i_irq_en, i_irq_req} = 8'h00;
    $display("test sleep done");
    await(3, 5000);
    chk("run_wdt_to", o_watchdog_timeout_flag, 1);
    i_wdt_src_sub = 1;
    sub_on = 1;
    i_watchdog_period_select = 0;
    tick(2);
    chk("wdt_src_lxt", o_wdt_src_is_lxt, i_sub_from_lxt);
    halt(1, 0);
    await(2, 1000);
    chk("sub_wdt_period", n + 12 > 512 && n < 520, 1);
    chk("sub_wdt_wake", o_pc_sp_reset, 1);
    {sub_on, i_wdt_src_sub, i_wdt_enable} = 0;
    i_porta_wake_enable_register = 8'h01 << idx;
    $display("test watchdog done");
    halt(0, 0);
    chk("deep_subclk", o_subclk_en, 0);
    go = 1;
    await(2, 12);
    go = 0;
    chk("deep_resume", o_resume_next, 1);
    chk("deep_hs_low", o_high_speed_osc_ready_flag, 0);
    await(0, 3000);
    chk("deep_hs_ready", n > 1018 && n < 1030, 1);
    $display("test deep sleep done");
    report_and_stop;
  end
endmodule // test_idle_mode_wakeup_control
